/* File: hdl/dsg_pkg.sv */
// Shared constants and types for the deep-sleep clock gating block.
// Assumes a 32-bit AXI4-Lite register port on a single 250 MHz clock.
package dsg_pkg;

  ////////////////////////////////////////////////////////////////////
  // Bus widths and answers
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] RUN_GATE_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h110;
  localparam logic [ADDR_W-1:0] DEEP_SLEEP_GATE_OFS = 12'h120;
  localparam logic [ADDR_W-1:0] ACTIVE_GATE_OFS = 12'h130;
  localparam logic [ADDR_W-1:0] FAULT_STATUS_OFS = 12'h134;

  ////////////////////////////////////////////////////////////////////
  // Gating register layout, shared by all three copies
  localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0040;
  localparam logic [DATA_W-1:0] GATE_RW_MASK = 32'h0101_0048;
  localparam int NUM_UNITS = 4;
  localparam int WATCHDOG_POS = 3;
  localparam int HIBERNATE_POS = 6;
  localparam int CONVERTER_POS = 16;
  localparam int CONTROLLER_AREA_POS = 24;
  localparam int UNIT_POS [NUM_UNITS] = '{WATCHDOG_POS, HIBERNATE_POS,
                                          CONVERTER_POS, CONTROLLER_AREA_POS};
  localparam logic [1:0] UNIT_WATCHDOG = 2'h0;
  localparam logic [1:0] UNIT_HIBERNATE = 2'h1;
  localparam logic [1:0] UNIT_CONVERTER = 2'h2;
  localparam logic [1:0] UNIT_CONTROLLER_AREA = 2'h3;

  ////////////////////////////////////////////////////////////////////
  // Run clock configuration layout
  localparam int AUTO_GATING_POS = 0;
  localparam logic [DATA_W-1:0] RUN_CLOCK_CONFIG_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RUN_CLOCK_CONFIG_MASK = 32'h0000_0001;
  localparam logic [DATA_W-1:0] FAULT_STATUS_MASK = 32'h0000_000F;

  ////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    DSG_MODE_RUN = 2'b00,
    DSG_MODE_SLEEP = 2'b01,
    DSG_MODE_DEEP = 2'b10
  } dsg_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] unit;
  } dsg_preq_t;

endpackage : dsg_pkg

/* File: hdl/dsg_enable_stage.sv */
// One registered clock enable for a single peripheral unit.
// Assumes the enable feeds an integrated clock gate cell downstream.
`timescale 1ns/1ps
module dsg_enable_stage #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Enable in and out
  input wire logic en_next,
  output logic en
);

  ////////////////////////////////////////////////////////////////////
  // Held in a flop so the gate cell never sees a combinational glitch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en <= RESET_VAL;
    end else begin
      en <= en_next;
    end
  end

endmodule : dsg_enable_stage

/* File: hdl/dsg_fault_guard.sv */
// Screens peripheral accesses against the live clock enables.
// Assumes requests are single-cycle strobes from the system bus fabric.
`timescale 1ns/1ps
module dsg_fault_guard #(
  parameter int NUM_UNITS = dsg_pkg::NUM_UNITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Request from the fabric and live enables
  input dsg_pkg::dsg_preq_t preq,
  input wire logic [NUM_UNITS-1:0] unit_en,
  // Passed request and fault answer
  output dsg_pkg::dsg_preq_t pfwd,
  output logic bus_fault,
  output logic [NUM_UNITS-1:0] fault_set
);

  logic hit_on;

  assign hit_on = unit_en[preq.unit];

  ////////////////////////////////////////////////////////////////////
  // Forward only to a clocked unit
  always_comb begin
    pfwd = preq;
    pfwd.valid = preq.valid & hit_on;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_fault <= 1'b0;
      fault_set <= '0;
    end else begin
      bus_fault <= preq.valid & ~hit_on;
      fault_set <= '0;
      if (preq.valid && !hit_on) begin
        fault_set[preq.unit] <= 1'b1;
      end
    end
  end

endmodule : dsg_fault_guard

/* File: hdl/dsg_clock_gating.sv */
// Peripheral clock gating control with run, sleep and deep-sleep sets.
// Assumes an AXI4-Lite master, one 250 MHz clock, and a power mode input
// from the core that changes only between bus transfers.
//
// Summary of operation
// - Each writable gating bit enables its unit's clock when set.
// - Accesses to an unclocked unit are answered with a bus fault.
// - Gating bits other than bit 6 reset to zero; register resets to 0x00000040.
// - Bit 6 gates hibernation clock, read/write, resets to one.
// - Bit 24 gates controller-area-network unit 0, resets to zero.
// - Bit 16 gates successive-approximation converter 0, resets to zero.
// - Bit 3 gates the watchdog clock, resets to zero.
// - Three gating registers: run, sleep, and deep-sleep at 0x120.
// - Sleep sets apply only while the automatic-gating bit is set.
// - Reserved bits are read-only zero; software preserves them.
`timescale 1ns/1ps
module dsg_clock_gating #(
  parameter int ADDR_W = dsg_pkg::ADDR_W,
  parameter int DATA_W = dsg_pkg::DATA_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Power mode from the core
  input dsg_pkg::dsg_mode_t power_mode,
  // Peripheral access screening
  input dsg_pkg::dsg_preq_t periph_req,
  output dsg_pkg::dsg_preq_t periph_fwd,
  output logic periph_bus_fault,
  // Unit clock enables
  output logic watchdog_clock_en,
  output logic hibernate_clock_en,
  output logic converter_clock_en,
  output logic controller_area_clock_en
);

  localparam int NU = dsg_pkg::NUM_UNITS;

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [DATA_W/8-1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;
  logic rd_go;
  logic [DATA_W-1:0] byte_mask;
  logic wr_hit;
  logic rd_hit;
  logic [DATA_W-1:0] rd_value;

  logic [DATA_W-1:0] run_gate_reg_zero;
  logic [DATA_W-1:0] sleep_gate_reg_zero;
  logic [DATA_W-1:0] deep_sleep_gate_reg_zero;
  logic [DATA_W-1:0] run_clock_config;
  logic [NU-1:0] fault_status_reg;
  logic [NU-1:0] fault_status_next;
  logic [NU-1:0] fault_set;
  logic [NU-1:0] fault_clr;
  logic auto_gating_select;
  logic [DATA_W-1:0] active_gate;
  logic [NU-1:0] unit_en_next;
  logic [NU-1:0] unit_en;
  logic [DATA_W-1:0] active_view;

  ////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  // Ready held low while a response waits, so one write is open at most
  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end
  end

  // Byte lanes widened to bit mask
  always_comb begin
    for (int b = 0; b < DATA_W / 8; b++) begin
      byte_mask[b*8 +: 8] = {8{w_strb_reg[b]}};
    end
  end

  always_comb begin
    unique case (aw_addr_reg)
      dsg_pkg::RUN_CLOCK_CONFIG_OFS: wr_hit = 1'b1;
      dsg_pkg::RUN_GATE_OFS: wr_hit = 1'b1;
      dsg_pkg::SLEEP_GATE_OFS: wr_hit = 1'b1;
      dsg_pkg::DEEP_SLEEP_GATE_OFS: wr_hit = 1'b1;
      dsg_pkg::ACTIVE_GATE_OFS: wr_hit = 1'b1;
      dsg_pkg::FAULT_STATUS_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= dsg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? dsg_pkg::RESP_OKAY : dsg_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////
  // Gating registers, one copy per operating mode
  // Only unit bits take writes; reserved bits never leave zero
  // run gating set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_gate_reg_zero <= dsg_pkg::GATE_RESET;
    end else if (wr_go && aw_addr_reg == dsg_pkg::RUN_GATE_OFS) begin
      run_gate_reg_zero <= (run_gate_reg_zero & ~(byte_mask & dsg_pkg::GATE_RW_MASK))
                         | (w_data_reg & byte_mask & dsg_pkg::GATE_RW_MASK);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sleep_gate_reg_zero <= dsg_pkg::GATE_RESET;
    end else if (wr_go && aw_addr_reg == dsg_pkg::SLEEP_GATE_OFS) begin
      sleep_gate_reg_zero <= (sleep_gate_reg_zero & ~(byte_mask & dsg_pkg::GATE_RW_MASK))
                           | (w_data_reg & byte_mask & dsg_pkg::GATE_RW_MASK);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      deep_sleep_gate_reg_zero <= dsg_pkg::GATE_RESET;
    end else if (wr_go && aw_addr_reg == dsg_pkg::DEEP_SLEEP_GATE_OFS) begin
      deep_sleep_gate_reg_zero <=
        (deep_sleep_gate_reg_zero & ~(byte_mask & dsg_pkg::GATE_RW_MASK))
        | (w_data_reg & byte_mask & dsg_pkg::GATE_RW_MASK);
    end
  end

  // Automatic gating select
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_clock_config <= dsg_pkg::RUN_CLOCK_CONFIG_RESET;
    end else if (wr_go && aw_addr_reg == dsg_pkg::RUN_CLOCK_CONFIG_OFS) begin
      run_clock_config <= (run_clock_config & ~(byte_mask & dsg_pkg::RUN_CLOCK_CONFIG_MASK))
                        | (w_data_reg & byte_mask & dsg_pkg::RUN_CLOCK_CONFIG_MASK);
    end
  end

  assign auto_gating_select = run_clock_config[dsg_pkg::AUTO_GATING_POS];

  ////////////////////////////////////////////////////////////////////
  // Sticky fault flags, write one to clear, set wins
  // Flags come from the guard one cycle after the refused access
  always_comb begin
    fault_clr = '0;
    if (wr_go && aw_addr_reg == dsg_pkg::FAULT_STATUS_OFS && w_strb_reg[0]) begin
      fault_clr = w_data_reg[NU-1:0];
    end
    fault_status_next = (fault_status_reg & ~fault_clr) | fault_set;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_status_reg <= '0;
    end else begin
      fault_status_reg <= fault_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Gating set in force
  // Unused mode code falls back to the run set
  // sleep sets need auto gating
  always_comb begin
    active_gate = run_gate_reg_zero;
    if (auto_gating_select) begin
      unique case (power_mode)
        dsg_pkg::DSG_MODE_RUN: active_gate = run_gate_reg_zero;
        dsg_pkg::DSG_MODE_SLEEP: active_gate = sleep_gate_reg_zero;
        dsg_pkg::DSG_MODE_DEEP: active_gate = deep_sleep_gate_reg_zero;
        default: active_gate = run_gate_reg_zero;
      endcase
    end
  end

  generate
    for (genvar u = 0; u < NU; u++) begin : g_unit
      assign unit_en_next[u] = active_gate[dsg_pkg::UNIT_POS[u]];
      dsg_enable_stage #(
        .RESET_VAL(dsg_pkg::GATE_RESET[dsg_pkg::UNIT_POS[u]])
      ) u_stage (
        .mclk(mclk),
        .nrst(nrst),
        .en_next(unit_en_next[u]),
        .en(unit_en[u])
      );
    end
  endgenerate

  assign watchdog_clock_en = unit_en[dsg_pkg::UNIT_WATCHDOG];
  assign hibernate_clock_en = unit_en[dsg_pkg::UNIT_HIBERNATE];
  assign converter_clock_en = unit_en[dsg_pkg::UNIT_CONVERTER];
  assign controller_area_clock_en = unit_en[dsg_pkg::UNIT_CONTROLLER_AREA];

  // Live enables shown in gating layout
  always_comb begin
    active_view = '0;
    for (int u = 0; u < NU; u++) begin
      active_view[dsg_pkg::UNIT_POS[u]] = unit_en[u];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Access screening against live enables
  // Screening follows the flopped enables, not the register contents
  // gated unit faults
  dsg_fault_guard #(
    .NUM_UNITS(NU)
  ) u_guard (
    .mclk(mclk),
    .nrst(nrst),
    .preq(periph_req),
    .unit_en(unit_en),
    .pfwd(periph_fwd),
    .bus_fault(periph_bus_fault),
    .fault_set(fault_set)
  );

  ////////////////////////////////////////////////////////////////////
  // Read channel
  // Address decoded at the handshake; answer held until taken
  assign s_axi_arready = ~rvalid_reg;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_hit = 1'b1;
    rd_value = '0;
    unique case (s_axi_araddr)
      dsg_pkg::RUN_CLOCK_CONFIG_OFS: rd_value = run_clock_config;
      dsg_pkg::RUN_GATE_OFS: rd_value = run_gate_reg_zero;
      dsg_pkg::SLEEP_GATE_OFS: rd_value = sleep_gate_reg_zero;
      dsg_pkg::DEEP_SLEEP_GATE_OFS: rd_value = deep_sleep_gate_reg_zero;
      dsg_pkg::ACTIVE_GATE_OFS: rd_value = active_view;
      dsg_pkg::FAULT_STATUS_OFS: rd_value = {{(DATA_W-NU){1'b0}}, fault_status_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= dsg_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_hit ? dsg_pkg::RESP_OKAY : dsg_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : dsg_clock_gating

/* File: tb/dsg_clock_gating_checker.sv */
// Port checker for the clock gating block.
// Assumes it is bound onto dsg_clock_gating.
`timescale 1ns/1ps
module dsg_clock_gating_checker #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input dsg_pkg::dsg_mode_t power_mode,
  input dsg_pkg::dsg_preq_t periph_req,
  input dsg_pkg::dsg_preq_t periph_fwd,
  input wire logic periph_bus_fault,
  input wire logic watchdog_clock_en,
  input wire logic hibernate_clock_en,
  input wire logic converter_clock_en,
  input wire logic controller_area_clock_en
);
  logic [3:0] en;
  logic hit;
  assign en = {controller_area_clock_en, converter_clock_en, hibernate_clock_en,
               watchdog_clock_en};
  assign hit = periph_req.valid && !en[periph_req.unit];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  a_fault_on_gated: assert property (hit |=> periph_bus_fault)
    else $error("no fault after gated access");
  a_fault_only_gated: assert property (!hit |=> !periph_bus_fault)
    else $error("fault without gated access");
  a_fwd_masked: assert property (periph_fwd.valid == (periph_req.valid && en[periph_req.unit]))
    else $error("forwarded strobe not masked");
  a_reset_enables: assert property ($rose(nrst) |-> en == 4'b0010)
    else $error("enables wrong after reset");
  a_enable_cause: assert property ($changed(en) |->
    $past(s_axi_bvalid) || $past(power_mode) != $past(power_mode, 2))
    else $error("enable changed without cause");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule : dsg_clock_gating_checker

bind dsg_clock_gating dsg_clock_gating_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .mclk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .power_mode,
  .periph_req, .periph_fwd, .periph_bus_fault, .watchdog_clock_en,
  .hibernate_clock_en, .converter_clock_en, .controller_area_clock_en);

/* File: tb/dsg_clock_gating_bench.sv */
// Self-checking bench for the clock gating block.
// Assumes registered AXI4-Lite answers and a one-cycle fault pulse.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dsg_clock_gating_bench;
  logic mclk = 0;
  logic nrst = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  dsg_pkg::dsg_mode_t power_mode = dsg_pkg::DSG_MODE_RUN;
  dsg_pkg::dsg_preq_t periph_req = '0, periph_fwd;
  logic periph_bus_fault, wd_en, hib_en, conv_en, ca_en, req_d = 0;
  int miscompares = 0, comparisons = 0;
  logic [65:0] rq [$];
  logic [65:0] re;
  logic [1:0] bq [$];
  logic fq [$];
  logic [31:0] seed = 32'h0000_593b, v;
  logic [31:0] sel [4] = '{32'h0000_0008, 32'h0001_0000, 32'h0100_0000, 32'h0000_0008};
  localparam logic [11:0] DEEP = dsg_pkg::DEEP_SLEEP_GATE_OFS;
  localparam logic [11:0] LIVE = dsg_pkg::ACTIVE_GATE_OFS;
  localparam logic [11:0] CFG = dsg_pkg::RUN_CLOCK_CONFIG_OFS;
  localparam logic [31:0] MASK = dsg_pkg::GATE_RW_MASK;

  always #2 mclk = ~mclk;

  dsg_clock_gating u_dsg_clock_gating (
    .mclk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .power_mode, .periph_req, .periph_fwd, .periph_bus_fault,
    .watchdog_clock_en(wd_en), .hibernate_clock_en(hib_en),
    .converter_clock_en(conv_en), .controller_area_clock_en(ca_en));

  //////////////////////////////////////////////////////////////////////
  // Result watcher: oldest note against each answer
  always @(posedge mclk) begin
    if (s_axi_rvalid === 1 && s_axi_rready === 1) begin
      re = rq.pop_front();
      `CHK({s_axi_rdata & re[65:34], s_axi_rresp}, re[33:0])
    end
    if (s_axi_bvalid === 1 && s_axi_bready === 1)
      `CHK(s_axi_bresp, bq.pop_front())
    if (req_d)
      `CHK(periph_bus_fault, fq.pop_front())
    if (periph_req.valid === 1)
      `CHK(periph_fwd, {!fq[0], periph_req.write, periph_req.unit})
    req_d <= periph_req.valid;
  end

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task finish_test;
    $display("checks %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task hang;
    miscompares++;
    finish_test;
  endtask : hang

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    bq.push_back(r);
    s_axi_awvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1;
    s_axi_wdata <= d;
    s_axi_bready <= 1;
    n = 0;
    while (!(s_axi_bvalid === 1 && s_axi_bready === 1)) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready === 1) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready === 1) s_axi_wvalid <= 0;
      if (++n > 50) hang;
    end
    s_axi_bready <= 0;
    @(posedge mclk);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = '1,
          input logic [1:0] r = 2'h0);
    int n;
    rq.push_back({m, d & m, r});
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    n = 0;
    while (!(s_axi_rvalid === 1 && s_axi_rready === 1)) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready === 1) s_axi_arvalid <= 0;
      if (++n > 50) hang;
    end
    s_axi_rready <= 0;
    @(posedge mclk);
  endtask : rd

  task pq(input logic [1:0] u, input logic f);
    fq.push_back(f);
    periph_req <= '{1'b1, 1'(xs()), u};
    @(posedge mclk);
    periph_req.valid <= 0;
    @(posedge mclk);
  endtask : pq

  task en_chk(input logic [31:0] r);
    `CHK({ca_en, conv_en, hib_en, wd_en}, {r[24], r[16], r[6], r[3]})
  endtask : en_chk

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1;
    @(posedge mclk);
    rd(DEEP, dsg_pkg::GATE_RESET);
    rd(dsg_pkg::SLEEP_GATE_OFS, dsg_pkg::GATE_RESET);
    rd(dsg_pkg::RUN_GATE_OFS, dsg_pkg::GATE_RESET);
    rd(CFG, 32'h0000_0000);
    en_chk(dsg_pkg::GATE_RESET);
    rd(12'h200, 32'h0000_0000, 32'h0000_0000, dsg_pkg::RESP_DECERR);
    wr(12'h204, '1, dsg_pkg::RESP_DECERR);
    $display("test reset done");
    power_mode <= dsg_pkg::DSG_MODE_DEEP;
    wr(CFG, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      v = 32'h0000_0001 << dsg_pkg::UNIT_POS[i];
      wr(DEEP, v | ~MASK);
      rd(DEEP, v);
      rd(LIVE, v);
      en_chk(v);
      for (int j = 0; j < 4; j++) pq(j[1:0], j != i);
    end
    rd(dsg_pkg::FAULT_STATUS_OFS, 32'h0000_000F);
    wr(dsg_pkg::FAULT_STATUS_OFS, 32'h0000_0005);
    rd(dsg_pkg::FAULT_STATUS_OFS, 32'h0000_000A);
    $display("test unit gating done");
    wr(dsg_pkg::RUN_GATE_OFS, sel[0]);
    wr(dsg_pkg::SLEEP_GATE_OFS, sel[1]);
    wr(DEEP, sel[2]);
    for (int k = 0; k < 4; k++) begin
      power_mode <= dsg_pkg::dsg_mode_t'(k);
      @(posedge mclk);
      rd(LIVE, sel[k]);
      en_chk(sel[k]);
    end
    wr(CFG, 32'h0000_0000);
    power_mode <= dsg_pkg::DSG_MODE_DEEP;
    rd(LIVE, sel[0]);
    $display("test mode select done");
    wr(CFG, 32'h0000_0001);
    repeat (8) begin
      v = xs();
      wr(DEEP, v);
      rd(DEEP, v & MASK);
      en_chk(v & MASK);
      pq(seed[1:0], !v[dsg_pkg::UNIT_POS[seed[1:0]]]);
    end
    $display("test random done");
    finish_test;
  end
endmodule : dsg_clock_gating_bench
